// ===== pkg/lvpd_pkg.sv
package lvpd_pkg;
  // Register bus
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] VSCFG_OFS = 32'h01f00010;
  localparam logic [31:0] RED_OFS = 32'h01f00014;
  localparam logic [31:0] GREEN_OFS = 32'h01f00018;
  localparam logic [31:0] BLUE_OFS = 32'h01f0001c;
  localparam logic [31:0] DHALF_OFS = 32'h01f00020;
  localparam logic [31:0] D47_OFS = 32'h01f00024;
  localparam logic [31:0] D35_OFS = 32'h01f00028;
  localparam logic [31:0] D23_OFS = 32'h01f0002c;
  localparam logic [31:0] STAT_OFS = 32'h01f000f0;
  // Virtual screen fields
  localparam int SKIP_LSB = 9;
  localparam int SKIP_W = 11;
  localparam int WIDTH_LSB = 0;
  localparam int WIDTH_W = 9;
  localparam int VSCFG_W = 20;
  localparam logic [19:0] VSCFG_RST = 20'h00000;
  // Frame start and bank
  localparam int FSTART_W = 21;
  localparam int BANK_W = 6;
  localparam int LINE_W = 10;
  localparam int FADDR_W = 28;
  // Shade tables
  localparam int SHADE_W = 4;
  localparam int BLUE_W = 16;
  localparam logic [31:0] RED_RST = 32'h00000000;
  localparam logic [31:0] GREEN_RST = 32'h00000000;
  localparam logic [15:0] BLUE_RST = 16'h0000;
  localparam logic [1:0] MODE_COLOUR = 2'h3;
  // Dither patterns: 1/2, 4/7, 3/5, 2/3
  localparam int NPAT = 4;
  localparam int PAT_MAX = 28;
  localparam int PHASE_W = 5;
  localparam int PAT_LEN [NPAT] = '{16, 28, 20, 12};
  localparam logic [27:0] PAT_RST [NPAT] = '{28'h000a5a5, 28'hba5da65, 28'h00a5a5f, 28'h0000d6b};
  localparam logic [31:0] PAT_OFS [NPAT] = '{DHALF_OFS, D47_OFS, D35_OFS, D23_OFS};
  // Shade that selects each pattern
  localparam logic [3:0] SHADE_PAT [NPAT] = '{4'h8, 4'h9, 4'ha, 4'hb};
  // Status fields
  localparam int STAT_LAYOUT_BIT = 21;
  localparam int STAT_ENABLE_BIT = 22;
endpackage

// ===== pkg/lvpd_cfg_if.sv
`timescale 1ns/1ps
interface lvpd_cfg_if;
  import lvpd_pkg::*;
  logic [WIDTH_W-1:0] view_width_halfwords;
  logic [SKIP_W-1:0] line_skip_halfwords;
  logic [PAT_MAX-1:0] pat [NPAT];
  modport src (output view_width_halfwords, output line_skip_halfwords, output pat);
  modport agen (input view_width_halfwords, input line_skip_halfwords);
  modport dith (input pat);
endinterface

// ===== verilog/lvpd_addr_gen.sv
`timescale 1ns/1ps
module lvpd_addr_gen (
  input wire logic clk,
  input wire logic resetn,
  lvpd_cfg_if.agen cfg,
  input wire logic video_output_enable,
  input wire logic frame_start,
  input wire logic fetch_strobe,
  input wire logic [lvpd_pkg::FSTART_W-1:0] upper_frame_start,
  input wire logic [lvpd_pkg::FSTART_W-1:0] lower_frame_start,
  input wire logic [lvpd_pkg::BANK_W-1:0] frame_bank_bits,
  output logic [lvpd_pkg::FADDR_W-1:0] upper_fetch_addr,
  output logic [lvpd_pkg::FADDR_W-1:0] lower_fetch_addr,
  output logic line_end
);
  import lvpd_pkg::*;

  logic [FSTART_W-1:0] ctr [2];
  logic [WIDTH_W-1:0] hw_pos;
  logic [BANK_W-1:0] bank;
  logic step;
  logic last_hw;

  // A zero width fetches nothing, so strobes are dropped
  assign step = fetch_strobe && video_output_enable && (cfg.view_width_halfwords != '0);
  assign last_hw = (hw_pos == cfg.view_width_halfwords - 9'h001);

  // Position within the displayed line
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hw_pos <= '0;
      line_end <= 1'b0;
    end
    else
    begin
      line_end <= step && last_hw && !frame_start;
      if (frame_start)
        hw_pos <= '0;
      else if (step)
        hw_pos <= last_hw ? '0 : hw_pos + 9'h001;
    end
  end

  // Bank is caught per frame; it must not move inside a frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bank <= '0;
    else if (frame_start)
      bank <= frame_bank_bits;
  end

  // Upper and lower half-word counters move in lock step
  for (genvar i = 0; i < 2; i++)
  begin : g_ctr
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        ctr[i] <= '0;
      else if (frame_start)
        ctr[i] <= (i == 0) ? upper_frame_start : lower_frame_start;
      else if (step && last_hw)
        ctr[i] <= ctr[i] + 21'h000001 + 21'(cfg.line_skip_halfwords);
      else if (step)
        ctr[i] <= ctr[i] + 21'h000001;
    end
  end

  // Half-word counter supplies bits 21:1, bank the bits above
  assign upper_fetch_addr = {bank, ctr[0], 1'b0};
  assign lower_fetch_addr = {bank, ctr[1], 1'b0};
endmodule // lvpd_addr_gen

// ===== verilog/lvpd_dither.sv
`timescale 1ns/1ps
module lvpd_dither (
  input wire logic clk,
  input wire logic resetn,
  lvpd_cfg_if.dith cfg,
  input wire logic frame_start,
  output logic [lvpd_pkg::NPAT-1:0] duty_bit
);
  import lvpd_pkg::*;

  logic [PHASE_W-1:0] phase [NPAT];

  // One phase per pattern, each wrapping at its own length
  for (genvar i = 0; i < NPAT; i++)
  begin : g_phase
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        phase[i] <= '0;
      else if (frame_start)
        phase[i] <= (phase[i] == PHASE_W'(PAT_LEN[i] - 1)) ? '0 : phase[i] + 5'h01;
    end
    // Current frame's bit of each pattern
    assign duty_bit[i] = cfg.pat[i][phase[i]];
  end
endmodule // lvpd_dither

// ===== verilog/lvpd_regs.sv
`timescale 1ns/1ps
module lvpd_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [lvpd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lvpd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lvpd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic video_output_enable,
  input wire logic [1:0] display_mode_select,
  input wire logic [lvpd_pkg::FSTART_W-1:0] upper_frame_start,
  input wire logic [lvpd_pkg::FSTART_W-1:0] lower_frame_start,
  input wire logic [lvpd_pkg::BANK_W-1:0] frame_bank_bits,
  input wire logic [lvpd_pkg::LINE_W-1:0] line_count_minus_one,
  input wire logic frame_start,
  input wire logic fetch_strobe,
  input wire logic pixel_strobe,
  input wire logic [2:0] red_code,
  input wire logic [2:0] green_code,
  input wire logic [1:0] blue_code,
  output logic [lvpd_pkg::FADDR_W-1:0] upper_fetch_addr,
  output logic [lvpd_pkg::FADDR_W-1:0] lower_fetch_addr,
  output logic line_end,
  output logic pixel_valid,
  output logic [lvpd_pkg::SHADE_W-1:0] red_shade,
  output logic [lvpd_pkg::SHADE_W-1:0] green_shade,
  output logic [lvpd_pkg::SHADE_W-1:0] blue_shade,
  output logic red_dot,
  output logic green_dot,
  output logic blue_dot
);
  import lvpd_pkg::*;

  lvpd_cfg_if cfg ();

  logic [VSCFG_W-1:0] virtual_screen_cfg;
  logic [31:0] red_shade_table;
  logic [31:0] green_shade_table;
  logic [BLUE_W-1:0] blue_shade_table;
  logic [NPAT-1:0] duty_bit;
  logic layout_ok;
  logic [31:0] layout_expect;
  logic [SHADE_W-1:0] next_red;
  logic [SHADE_W-1:0] next_green;
  logic [SHADE_W-1:0] next_blue;
  logic colour_mode;
  logic wr_vscfg;
  logic wr_red;
  logic wr_green;
  logic wr_blue;
  logic [NPAT-1:0] wr_pat;

  // Full-address compare, so aliases never hit
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Nibble n of a lookup table
  function automatic logic [3:0] lut_nibble(input logic [31:0] tbl, input logic [2:0] code);
    lut_nibble = tbl[{code, 2'b00} +: 4];
  endfunction

  // Shades below the half duty stay dark, above two-thirds stay lit
  function automatic logic shade_dot(input logic [3:0] shade, input logic [NPAT-1:0] bits);
    logic dot;
    dot = (shade > SHADE_PAT[NPAT-1]);
    for (int k = 0; k < NPAT; k++)
    begin
      if (shade == SHADE_PAT[k])
        dot = bits[k];
    end
    shade_dot = dot;
  endfunction

  // One write strobe per register; exact address match only
  assign wr_vscfg = reg_wr && hit(reg_addr, VSCFG_OFS);
  assign wr_red = reg_wr && hit(reg_addr, RED_OFS);
  assign wr_green = reg_wr && hit(reg_addr, GREEN_OFS);
  assign wr_blue = reg_wr && hit(reg_addr, BLUE_OFS);

  // Virtual screen configuration; software keeps it still while video runs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      virtual_screen_cfg <= VSCFG_RST;
    else if (wr_vscfg)
      virtual_screen_cfg <= reg_wdata[VSCFG_W-1:0];
  end

  // Width and skip fields as seen by the fetch logic
  assign cfg.line_skip_halfwords = virtual_screen_cfg[SKIP_LSB +: SKIP_W];
  assign cfg.view_width_halfwords = virtual_screen_cfg[WIDTH_LSB +: WIDTH_W];

  // Red shade table
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      red_shade_table <= RED_RST;
    else if (wr_red)
      red_shade_table <= reg_wdata;
  end

  // Green shade table
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      green_shade_table <= GREEN_RST;
    else if (wr_green)
      green_shade_table <= reg_wdata;
  end

  // Blue shade table; only four codes, so the upper half-word is dropped
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      blue_shade_table <= BLUE_RST;
    else if (wr_blue)
      blue_shade_table <= reg_wdata[BLUE_W-1:0];
  end

  // Dither duty patterns; unused upper bits held at zero
  for (genvar i = 0; i < NPAT; i++)
  begin : g_pat
    assign wr_pat[i] = reg_wr && hit(reg_addr, PAT_OFS[i]);
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        cfg.pat[i] <= PAT_RST[i];
      else if (wr_pat[i])
        cfg.pat[i] <= reg_wdata[PAT_MAX-1:0] & ((28'h0000001 << PAT_LEN[i]) - 28'h0000001);
    end
  end

  // Fetch address counters for upper and lower panels
  lvpd_addr_gen u_agen (
    .clk(clk),
    .resetn(resetn),
    .cfg(cfg.agen),
    .video_output_enable(video_output_enable),
    .frame_start(frame_start),
    .fetch_strobe(fetch_strobe),
    .upper_frame_start(upper_frame_start),
    .lower_frame_start(lower_frame_start),
    .frame_bank_bits(frame_bank_bits),
    .upper_fetch_addr(upper_fetch_addr),
    .lower_fetch_addr(lower_fetch_addr),
    .line_end(line_end)
  );

  // Frame-stepped pattern bits
  lvpd_dither u_dith (
    .clk(clk),
    .resetn(resetn),
    .cfg(cfg.dith),
    .frame_start(frame_start),
    .duty_bit(duty_bit)
  );

  // Table lookups; gray and mono modes bypass them entirely
  assign colour_mode = (display_mode_select == MODE_COLOUR);
  assign next_red = lut_nibble(red_shade_table, red_code);
  assign next_green = lut_nibble(green_shade_table, green_code);
  assign next_blue = lut_nibble({16'h0000, blue_shade_table}, {1'b0, blue_code});

  // Pixel valid trails the strobe by one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pixel_valid <= 1'b0;
    else
      pixel_valid <= pixel_strobe;
  end

  // Shades hold between strobes so the panel side may sample late
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      red_shade <= '0;
      green_shade <= '0;
      blue_shade <= '0;
    end
    else if (pixel_strobe)
    begin
      red_shade <= colour_mode ? next_red : '0;
      green_shade <= colour_mode ? next_green : '0;
      blue_shade <= colour_mode ? next_blue : '0;
    end
  end

  // Dithered dots use the phase in force before this cycle's frame start
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      red_dot <= 1'b0;
      green_dot <= 1'b0;
      blue_dot <= 1'b0;
    end
    else if (pixel_strobe)
    begin
      red_dot <= colour_mode && shade_dot(next_red, duty_bit);
      green_dot <= colour_mode && shade_dot(next_green, duty_bit);
      blue_dot <= colour_mode && shade_dot(next_blue, duty_bit);
    end
  end

  // Checks software's lower start against the layout; a mismatch tears dual scan
  assign layout_expect = 32'(upper_frame_start)
    + (32'(cfg.view_width_halfwords) + 32'(cfg.line_skip_halfwords))
    * (32'(line_count_minus_one) + 32'h00000001);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      layout_ok <= 1'b0;
    else
      layout_ok <= (layout_expect[FSTART_W-1:0] == lower_frame_start);
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      if (hit(reg_addr, VSCFG_OFS))
        reg_rdata <= {12'h000, virtual_screen_cfg};
      if (hit(reg_addr, RED_OFS))
        reg_rdata <= red_shade_table;
      if (hit(reg_addr, GREEN_OFS))
        reg_rdata <= green_shade_table;
      if (hit(reg_addr, BLUE_OFS))
        reg_rdata <= {16'h0000, blue_shade_table};
      for (int k = 0; k < NPAT; k++)
      begin
        if (hit(reg_addr, PAT_OFS[k]))
          reg_rdata <= {4'h0, cfg.pat[k]};
      end
      if (hit(reg_addr, STAT_OFS))
      begin
        reg_rdata <= '0;
        reg_rdata[FSTART_W-1:0] <= upper_fetch_addr[FSTART_W:1];
        reg_rdata[STAT_LAYOUT_BIT] <= layout_ok;
        reg_rdata[STAT_ENABLE_BIT] <= video_output_enable;
      end
    end
    else
      reg_rdata <= '0;
  end
endmodule // lvpd_regs

// ===== tb/lvpd_regs_asserts.sv
`timescale 1ns/1ps
module lvpd_regs_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_rd,
  input wire logic [lvpd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic video_output_enable,
  input wire logic [1:0] display_mode_select,
  input wire logic [lvpd_pkg::FSTART_W-1:0] upper_frame_start,
  input wire logic [lvpd_pkg::FSTART_W-1:0] lower_frame_start,
  input wire logic [lvpd_pkg::BANK_W-1:0] frame_bank_bits,
  input wire logic frame_start,
  input wire logic fetch_strobe,
  input wire logic pixel_strobe,
  input wire logic [lvpd_pkg::FADDR_W-1:0] upper_fetch_addr,
  input wire logic [lvpd_pkg::FADDR_W-1:0] lower_fetch_addr,
  input wire logic line_end,
  input wire logic pixel_valid,
  input wire logic [lvpd_pkg::SHADE_W-1:0] red_shade,
  input wire logic [lvpd_pkg::SHADE_W-1:0] green_shade,
  input wire logic [lvpd_pkg::SHADE_W-1:0] blue_shade,
  input wire logic red_dot
);
  import lvpd_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_pixel_pulse: assert property (pixel_strobe |=> pixel_valid)
    else $error("pixel valid missing after strobe");
  a_pixel_idle: assert property (!pixel_strobe |=> !pixel_valid)
    else $error("pixel valid without strobe");
  // Outside colour mode the tables are bypassed
  a_shade_mono: assert property (pixel_strobe && display_mode_select != MODE_COLOUR
    |=> red_shade == 4'h0 && green_shade == 4'h0 && blue_shade == 4'h0 && !red_dot)
    else $error("shade not zero outside colour mode");
  a_shade_hold: assert property (!pixel_strobe |=> $stable(red_shade) && $stable(blue_shade))
    else $error("shade moved without strobe");
  // Frame start loads bank and half-word start
  a_upper_load: assert property (frame_start
    |=> upper_fetch_addr == {$past(frame_bank_bits), $past(upper_frame_start), 1'b0})
    else $error("upper fetch address not loaded");
  a_lower_load: assert property (frame_start
    |=> lower_fetch_addr == {$past(frame_bank_bits), $past(lower_frame_start), 1'b0})
    else $error("lower fetch address not loaded");
  a_fetch_off: assert property (fetch_strobe && !frame_start && !video_output_enable
    |=> $stable(upper_fetch_addr) && $stable(lower_fetch_addr))
    else $error("fetch counted while video off");
  a_addr_idle: assert property (!fetch_strobe && !frame_start |=> $stable(upper_fetch_addr))
    else $error("fetch address moved without event");
  a_line_cause: assert property (line_end |-> $past(fetch_strobe) && $past(video_output_enable))
    else $error("line end without counted fetch");
  // Inside a line the counter moves one half-word
  a_step_one: assert property (fetch_strobe && !frame_start && video_output_enable ##1 !line_end
    |-> upper_fetch_addr == $past(upper_fetch_addr) + 28'h2)
    else $error("fetch address step wrong");
  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
  c_line: cover property (line_end);
  c_dot: cover property (pixel_valid && red_dot);
endmodule // lvpd_regs_chk

bind lvpd_regs lvpd_regs_chk i_chk (.clk, .resetn, .reg_rd, .reg_rdata, .video_output_enable,
  .display_mode_select, .upper_frame_start, .lower_frame_start, .frame_bank_bits, .frame_start,
  .fetch_strobe, .pixel_strobe, .upper_fetch_addr, .lower_fetch_addr, .line_end, .pixel_valid,
  .red_shade, .green_shade, .blue_shade, .red_dot);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, want, seen) begin checks_done++; if ((seen) !== (want)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", what, want, seen); end end
module tb_top;
  import lvpd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, video_output_enable = 1'b0;
  logic [1:0] display_mode_select = 2'h0, blue_code = 2'h0;
  logic [20:0] upper_frame_start = 21'h0, lower_frame_start = 21'h0;
  logic [5:0] frame_bank_bits = 6'h0;
  logic [9:0] line_count_minus_one = 10'h0;
  logic frame_start = 1'b0, fetch_strobe = 1'b0, pixel_strobe = 1'b0;
  logic [2:0] red_code = 3'h0, green_code = 3'h0;
  logic [27:0] upper_fetch_addr, lower_fetch_addr;
  logic line_end, pixel_valid, red_dot, green_dot, blue_dot;
  logic [3:0] red_shade, green_shade, blue_shade;
  int fail_count = 0, checks_done = 0, fs_n = 0;
  logic [31:0] rofs [8] = '{VSCFG_OFS, RED_OFS, GREEN_OFS, BLUE_OFS, DHALF_OFS, D47_OFS,
    D35_OFS, D23_OFS};
  logic [31:0] rrst [8] = '{32'(VSCFG_RST), RED_RST, GREEN_RST, 32'(BLUE_RST), 32'(PAT_RST[0]),
    32'(PAT_RST[1]), 32'(PAT_RST[2]), 32'(PAT_RST[3])};
  int rw [8] = '{20, 32, 32, 16, 16, 28, 20, 12};
  logic [31:0] rt = 32'hfedcba98, gt = 32'h01234567, bt = 32'h00005af3;
  lvpd_regs i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .video_output_enable, .display_mode_select, .upper_frame_start, .lower_frame_start,
    .frame_bank_bits, .line_count_minus_one, .frame_start, .fetch_strobe, .pixel_strobe,
    .red_code, .green_code, .blue_code, .upper_fetch_addr, .lower_fetch_addr, .line_end,
    .pixel_valid, .red_shade, .green_shade, .blue_shade, .red_dot, .green_dot, .blue_dot);
  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Data is looked at in the one cycle it stands
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  // One-cycle pulses; outputs are read once the answering edge has landed
  task automatic step(input logic f, input logic s, input logic p, input logic [2:0] n);
    @(posedge clk);
    frame_start <= f;
    fetch_strobe <= s;
    pixel_strobe <= p;
    red_code <= n;
    green_code <= n;
    blue_code <= n[1:0];
    @(posedge clk);
    frame_start <= 1'b0;
    fetch_strobe <= 1'b0;
    pixel_strobe <= 1'b0;
    #1 fs_n += int'(f);
  endtask
  task automatic complete_run;
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Expected dot: dark below 8, lit from c, one duty pattern per shade between
  function automatic logic exp_dot(input logic [3:0] s, input int f);
    if (s >= 4'hc)
      return 1'b1;
    if (s < 4'h8)
      return 1'b0;
    return PAT_RST[s - 4'h8][f % PAT_LEN[s - 4'h8]];
  endfunction
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(rofs[i], rrst[i]);
    $display("test reset_values done");
    wr(VSCFG_OFS, 32'h00000602);
    upper_frame_start <= 21'h10;
    lower_frame_start <= 21'h10 + (21'h2 + 21'h3) * (21'h0 + 21'h1);
    frame_bank_bits <= 6'h05;
    video_output_enable <= 1'b1;
    step(1'b1, 1'b0, 1'b0, 3'h0);
    `CHK("upper_fetch_addr", {6'h05, 21'h10, 1'b0}, upper_fetch_addr)
    `CHK("lower_fetch_addr", {6'h05, 21'h15, 1'b0}, lower_fetch_addr)
    step(1'b0, 1'b1, 1'b0, 3'h0);
    `CHK("upper_fetch_addr", {6'h05, 21'h11, 1'b0}, upper_fetch_addr)
    `CHK("lower_fetch_addr", {6'h05, 21'h16, 1'b0}, lower_fetch_addr)
    `CHK("line_end", 1'b0, line_end)
    step(1'b0, 1'b1, 1'b0, 3'h0);
    `CHK("upper_fetch_addr", {6'h05, 21'h15, 1'b0}, upper_fetch_addr)
    `CHK("lower_fetch_addr", {6'h05, 21'h1a, 1'b0}, lower_fetch_addr)
    `CHK("line_end", 1'b1, line_end)
    rd(STAT_OFS, (32'h1 << STAT_ENABLE_BIT) | (32'h1 << STAT_LAYOUT_BIT) | 32'h15);
    @(posedge clk);
    video_output_enable <= 1'b0;
    step(1'b0, 1'b1, 1'b0, 3'h0);
    `CHK("upper_fetch_addr", {6'h05, 21'h15, 1'b0}, upper_fetch_addr)
    $display("test fetch_step done");
    wr(RED_OFS, rt);
    wr(GREEN_OFS, gt);
    wr(BLUE_OFS, bt);
    display_mode_select <= MODE_COLOUR;
    // Shades 8 to b pick the four duty patterns, c and up light the dot
    for (int f = 0; f < 3; f++)
    begin
      step(1'b1, 1'b0, 1'b0, 3'h0);
      for (int n = 0; n < 8; n++)
      begin
        step(1'b0, 1'b0, 1'b1, 3'(n));
        `CHK("pixel_valid", 1'b1, pixel_valid)
        `CHK("red_shade", rt[4*n+:4], red_shade)
        `CHK("green_shade", gt[4*n+:4], green_shade)
        `CHK("blue_shade", bt[4*(n%4)+:4], blue_shade)
        `CHK("red_dot", exp_dot(rt[4*n+:4], fs_n), red_dot)
        `CHK("green_dot", exp_dot(gt[4*n+:4], fs_n), green_dot)
        `CHK("blue_dot", exp_dot(bt[4*(n%4)+:4], fs_n), blue_dot)
      end
    end
    @(posedge clk);
    display_mode_select <= 2'h2;
    step(1'b0, 1'b0, 1'b1, 3'h5);
    `CHK("red_shade", 4'h0, red_shade)
    `CHK("green_shade", 4'h0, green_shade)
    `CHK("blue_shade", 4'h0, blue_shade)
    `CHK("red_dot", 1'b0, red_dot)
    `CHK("blue_dot", 1'b0, blue_dot)
    $display("test shade_dither done");
    for (int i = 0; i < 8; i++)
    begin
      wr(rofs[i], 32'hffffffff);
      rd(rofs[i], 32'((64'h1 << rw[i]) - 64'h1));
    end
    wr(32'h01f00030, 32'hffffffff);
    rd(32'h01f00030, 32'h0);
    $display("test write_masks done");
    complete_run;
  end
  // The run takes about 0.7 us; far beyond that means a hang
  initial
  begin
    #20us;
    fail_count++;
    complete_run;
  end
endmodule // tb_top
